// >>> hw/rswt_map.svh
// register map, field positions, reset values and timing of the reset block
`ifndef RSWT_MAP_SVH
`define RSWT_MAP_SVH

// ==========================================
// i/o addresses
`define RSWT_ADDR_WDOG_RESTART 8'h21
`define RSWT_ADDR_RC_WAKE      8'h22
`define RSWT_ADDR_FREE_COUNT   8'h23
`define RSWT_ADDR_STATUS_CTRL  8'hff

// ==========================================
// status_control fields
`define RSWT_SC_RUN     0
`define RSWT_SC_SUSPEND 3
`define RSWT_SC_POR     4
`define RSWT_SC_BUSRST  5
`define RSWT_SC_WDOG    6
`define RSWT_SC_POR_VAL 8'h19
`define RSWT_SC_WMASK   8'h79

// ==========================================
// timing
`define RSWT_CLK_PS       25000
`define RSWT_TICK_NS      1000
`define RSWT_SE0_MIN_NS   8000
`define RSWT_WAKE_MAX_US  256
`define RSWT_WDOG_HOLD_US 8192
`define RSWT_WDOG_BITS    4
`define RSWT_TMR_BITS     11

`endif

// >>> hw/rswt_pkg.sv
// types of the reset, suspend and watchdog timer block
package rswt_pkg;

   typedef enum logic [4:0] {
      RSWT_ST_RUN    = 5'h01,
      RSWT_ST_SUSP   = 5'h02,
      RSWT_ST_WAKE   = 5'h04,
      RSWT_ST_WDRST  = 5'h08,
      RSWT_ST_BUSRST = 5'h10
   } rswt_state_type;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } rswt_io_req_type;

   typedef struct packed {
      rswt_state_type st;
      logic [7:0]     status_control;
      logic           drvLow;
      logic           porWake;
      logic [5:0]     prescale;
      logic [10:0]    tmr;
      logic [3:0]     wdt;
      logic [19:0]    holdCnt;
      logic [8:0]     se0Cnt;
      logic           cextPrev;
      logic [7:0]     rdData;
      logic           irq128;
      logic           irq1ms;
      logic           cextIrq;
      logic           fetchZero;
      logic           rstPulse;
      logic           cpuHold;
      logic           oscStop;
   } rswt_regs_type;

endpackage

// >>> hw/rswt_reset_suspend_timer.sv
// reset, suspend, watchdog and free-running timer control
//
// Function
// - reset causes recorded in status bits 4-6
// - run bit set at power-on, clear-only
// - fetch from zero after reset unless suspended
// - suspend stops clock, wakes on activity
// - power-on loads status 00011001, enters suspend
// - after power-on only bus activity wakes
// - watchdog: four-bit counter, msb rise resets
// - any restart write clears watchdog counter
// - watchdog advances each 1.024 ms tick
// - watchdog reset holds processor 8.192 ms
// - watchdog disables transmitter, releases rc pin
// - bus reset detected on SE0, 8-16 us
// - bus reset sets bit5, ends suspend
// - timers and watchdog off in suspend
// - fully operational within 256 us of wake
// - wake resumes at next instruction
// - wake register bit0 drives open-drain pin
// - wake register reads pin, released in reset
// - microsecond counter, low byte readable
// - counter cleared at power-on and suspend entry
// - periodic 128 us and 1.024 ms requests
// - every reset restores defaults, releases rc pin
`timescale 1ns/1ps
`include "rswt_map.svh"

module rswt_reset_suspend_timer
#(
   parameter int unsigned WAKE_CYC =
      32'((64'(`RSWT_WAKE_MAX_US) * 64'd1000000) / 64'(`RSWT_CLK_PS)),
   parameter int unsigned WDOG_HOLD_CYC =
      32'((64'(`RSWT_WDOG_HOLD_US) * 64'd1000000) / 64'(`RSWT_CLK_PS))
)
(
   // clock and power-on reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // i/o read and write instructions
   input  wire rswt_pkg::rswt_io_req_type ioReq,
   output logic [7:0]                     ioRdData,
   // usb lines and wake sources
   input  wire logic                      dPlus,
   input  wire logic                      dMinus,
   input  wire logic                      gpioWake,
   // rc wake pin
   input  wire logic                      rcWakeIn,
   output logic                           rcWakeOut,
   output logic                           rcWakeOe,
   // processor and system control
   output logic                           cpuHold,
   output logic                           cpuRun,
   output logic                           cpuFetchZero,
   output logic                           oscStop,
   output logic                           sysResetPulse,
   output logic                           usbTxDisable,
   // periodic and wake interrupt requests
   output logic                           irq128us,
   output logic                           irq1ms,
   output logic                           irqRcWake
);
   import rswt_pkg::*;

   // ==========================================
   // derived cycle counts
   localparam logic [5:0] TICK_CYC =
      6'((`RSWT_TICK_NS * 1000) / `RSWT_CLK_PS);
   localparam logic [8:0] SE0_CYC =
      9'((`RSWT_SE0_MIN_NS * 1000 + `RSWT_CLK_PS - 1) / `RSWT_CLK_PS);
   localparam logic [19:0] WAKE_LAST = 20'(WAKE_CYC - 1);
   localparam logic [19:0] HOLD_LAST = 20'(WDOG_HOLD_CYC - 1);

   localparam rswt_regs_type POR_REGS = '{
      st:       RSWT_ST_SUSP,
      status_control:      `RSWT_SC_POR_VAL,
      porWake:  1'b1,
      // pin idles high, so no false wake edge after reset
      cextPrev: 1'b1,
      cpuHold:  1'b1,
      oscStop:  1'b1,
      default:  '0
   };

   rswt_regs_type s_q;
   rswt_regs_type s_d;

   logic se0;
   logic busActive;
   logic cextRise;
   logic usTick;
   logic tick1ms;
   logic ioOk;

   // ==========================================
   // next-state logic
   always_comb
   begin
      s_d           = s_q;
      s_d.irq128    = 1'b0;
      s_d.irq1ms    = 1'b0;
      s_d.fetchZero = 1'b0;
      s_d.rstPulse  = 1'b0;
      se0       = !dPlus && !dMinus;
      busActive = !(dMinus && !dPlus);
      cextRise  = rcWakeIn && !s_q.cextPrev;
      usTick    = 1'b0;
      tick1ms   = 1'b0;
      ioOk      = (s_q.st == RSWT_ST_RUN) && s_q.status_control[`RSWT_SC_RUN];

      s_d.cextPrev = rcWakeIn;
      s_d.cextIrq  = cextRise;

      // se0 filter, always alive like the receiver
      if (se0 && s_q.se0Cnt != SE0_CYC)
         s_d.se0Cnt = s_q.se0Cnt + 9'h001;
      else if (!se0)
         s_d.se0Cnt = 9'h000;

      // microsecond timer, frozen during suspend
      if (s_q.st != RSWT_ST_SUSP)
      begin
         if (s_q.prescale == TICK_CYC - 6'h01)
         begin
            s_d.prescale = 6'h00;
            usTick       = 1'b1;
         end
         else
            s_d.prescale = s_q.prescale + 6'h01;
      end
      if (usTick)
      begin
         s_d.tmr    = s_q.tmr + 11'h001;
         s_d.irq128 = (s_q.tmr[6:0] == 7'h7f);
         s_d.irq1ms = (s_q.tmr[9:0] == 10'h3ff);
         tick1ms    = (s_q.tmr[9:0] == 10'h3ff);
      end

      // watchdog counts only while running
      if (s_q.st == RSWT_ST_RUN && tick1ms)
         s_d.wdt = s_q.wdt + 4'h1;

      // register reads
      if (ioReq.rd)
      begin
         unique case (ioReq.addr)
            `RSWT_ADDR_STATUS_CTRL: s_d.rdData = s_q.status_control;
            `RSWT_ADDR_RC_WAKE:     s_d.rdData = {7'h00, rcWakeIn};
            `RSWT_ADDR_FREE_COUNT:  s_d.rdData = s_q.tmr[7:0];
            default:                s_d.rdData = 8'h00;
         endcase
      end

      // register writes
      if (ioReq.wr && ioOk)
      begin
         unique case (ioReq.addr)
            `RSWT_ADDR_WDOG_RESTART:
               s_d.wdt = 4'h0;
            `RSWT_ADDR_RC_WAKE:
               s_d.drvLow = !ioReq.data[0];
            `RSWT_ADDR_STATUS_CTRL:
            begin
               // reserved bits forced low
               s_d.status_control = ioReq.data & `RSWT_SC_WMASK;
               s_d.status_control[`RSWT_SC_RUN] = s_q.status_control[`RSWT_SC_RUN]
                                     & ioReq.data[`RSWT_SC_RUN];
               if (ioReq.data[`RSWT_SC_SUSPEND])
               begin
                  s_d.st       = RSWT_ST_SUSP;
                  s_d.tmr      = '0;
                  s_d.irq128   = 1'b0;
                  s_d.irq1ms   = 1'b0;
                  s_d.prescale = 6'h00;
               end
            end
            default:
               s_d.rdData = s_q.rdData;
         endcase
      end

      // state sequencing
      unique case (s_q.st)
         RSWT_ST_RUN:
            if (tick1ms && s_q.wdt == 4'h7)
            begin
               s_d.st       = RSWT_ST_WDRST;
               s_d.holdCnt  = '0;
               s_d.wdt      = 4'h0;
               s_d.status_control      = 8'h41;
               s_d.drvLow   = 1'b0;
               s_d.rstPulse = 1'b1;
            end
         RSWT_ST_SUSP:
            if (busActive || (!s_q.porWake && (gpioWake || cextRise)))
            begin
               s_d.st      = RSWT_ST_WAKE;
               s_d.holdCnt = '0;
               s_d.status_control[`RSWT_SC_SUSPEND] = 1'b0;
            end
         RSWT_ST_WAKE:
            if (s_q.holdCnt == WAKE_LAST)
            begin
               s_d.st        = RSWT_ST_RUN;
               s_d.fetchZero = s_q.porWake;
               s_d.porWake   = 1'b0;
            end
            else
               s_d.holdCnt = s_q.holdCnt + 20'h00001;
         RSWT_ST_WDRST:
            if (s_q.holdCnt == HOLD_LAST)
            begin
               s_d.st        = RSWT_ST_RUN;
               s_d.fetchZero = 1'b1;
            end
            else
               s_d.holdCnt = s_q.holdCnt + 20'h00001;
         RSWT_ST_BUSRST:
            if (!se0)
            begin
               s_d.st        = RSWT_ST_RUN;
               s_d.fetchZero = 1'b1;
            end
      endcase

      // bus reset wins over everything, also wakes from suspend
      if (s_q.se0Cnt == SE0_CYC && s_q.st != RSWT_ST_BUSRST)
      begin
         s_d.st       = RSWT_ST_BUSRST;
         s_d.wdt      = 4'h0;
         s_d.status_control      = (s_q.status_control & 8'h50) | 8'h21;
         s_d.drvLow   = 1'b0;
         s_d.porWake  = 1'b0;
         s_d.rstPulse = 1'b1;
      end

      s_d.cpuHold = (s_d.st != RSWT_ST_RUN);
      s_d.oscStop = (s_d.st == RSWT_ST_SUSP);
   end

   // ==========================================
   // state register
   always_ff @(posedge clk)
   begin
      if (!resetn)
         s_q <= POR_REGS;
      else
         s_q <= s_d;
   end

   // ==========================================
   // outputs
   assign ioRdData      = s_q.rdData;
   assign rcWakeOut     = 1'b0;
   assign rcWakeOe      = s_q.drvLow;
   assign cpuHold       = s_q.cpuHold;
   assign cpuRun        = s_q.status_control[`RSWT_SC_RUN];
   assign cpuFetchZero  = s_q.fetchZero;
   assign oscStop       = s_q.oscStop;
   assign sysResetPulse = s_q.rstPulse;
   assign usbTxDisable  = s_q.status_control[`RSWT_SC_WDOG];
   assign irq128us      = s_q.irq128;
   assign irq1ms        = s_q.irq1ms;
   assign irqRcWake     = s_q.cextIrq;

endmodule

// >>> sim/rswt_check_properties.sv
// port checker of the reset, suspend and timer block
`timescale 1ns/1ps
module rswt_check
#(
   parameter int unsigned WAKE_CYC      = 8,
   parameter int unsigned WDOG_HOLD_CYC = 16
)
(
   // clock and reset
   input wire logic                      clk,
   input wire logic                      resetn,
   // i/o and usb lines
   input wire rswt_pkg::rswt_io_req_type ioReq,
   input wire logic [7:0]                ioRdData,
   input wire logic                      dPlus,
   input wire logic                      dMinus,
   // control outputs
   input wire logic                      rcWakeOe,
   input wire logic                      cpuHold,
   input wire logic                      cpuRun,
   input wire logic                      cpuFetchZero,
   input wire logic                      oscStop,
   input wire logic                      sysResetPulse,
   input wire logic                      usbTxDisable,
   input wire logic                      irq128us,
   input wire logic                      irq1ms
);
   import rswt_pkg::*;
   // ======
   // helpers
   logic       se0;
   logic [9:0] se0Cnt_q;
   assign se0 = !dPlus && !dMinus;
   always_ff @(posedge clk)
   begin
      if (!resetn || !se0)
         se0Cnt_q <= 10'h000;
      else if (se0Cnt_q != 10'h3ff)
         se0Cnt_q <= se0Cnt_q + 10'h001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence runWr(a);
      ioReq.wr && ioReq.addr == a && cpuRun && !cpuHold;
   endsequence
   // ======
   // properties
   AST_SUSP: assert property (runWr(8'hff) ##0 ioReq.data[3]
      |=> oscStop && cpuHold) else $error("suspend not entered");
   AST_RC_OE: assert property (runWr(8'h22)
      |=> rcWakeOe == !$past(ioReq.data[0])) else $error("rc pin drive");
   AST_RSVD: assert property (ioReq.rd && ioReq.addr == 8'hff
      |=> (ioRdData & 8'h86) == 8'h00) else $error("reserved bits");
   AST_OSC: assert property (oscStop |-> cpuHold)
      else $error("cpu free in suspend");
   AST_SE0: assert property (se0Cnt_q > 10'd640 |-> cpuHold)
      else $error("bus reset missed");
   AST_RUN: assert property ($rose(cpuRun) |-> sysResetPulse)
      else $error("run bit set without reset");
   AST_TXD: assert property ($rose(usbTxDisable)
      && !$past(ioReq.wr) |-> sysResetPulse && cpuHold)
      else $error("tx disable cause");
   AST_FETCH: assert property (cpuFetchZero
      |-> $past(cpuHold) && !oscStop) else $error("fetch zero cause");
   AST_WAKE: assert property ($fell(oscStop) && !se0
      |-> ##[1:1000] !cpuHold) else $error("wake too slow");
   AST_NEST: assert property (irq1ms |-> irq128us)
      else $error("periodic requests apart");
   AST_GAP: assert property (irq128us |=> !irq128us [*8])
      else $error("periodic request too soon");
   AST_SLEEP: assert property (oscStop |-> !irq128us && !irq1ms)
      else $error("timer runs in suspend");
endmodule

bind rswt_reset_suspend_timer rswt_check #(.WAKE_CYC(WAKE_CYC),
   .WDOG_HOLD_CYC(WDOG_HOLD_CYC)) u_rswt_check (.clk(clk),
   .resetn(resetn), .ioReq(ioReq), .ioRdData(ioRdData), .dPlus(dPlus),
   .dMinus(dMinus), .rcWakeOe(rcWakeOe), .cpuHold(cpuHold),
   .cpuRun(cpuRun), .cpuFetchZero(cpuFetchZero), .oscStop(oscStop),
   .sysResetPulse(sysResetPulse), .usbTxDisable(usbTxDisable),
   .irq128us(irq128us), .irq1ms(irq1ms));

// >>> sim/rswt_host_rc.sv
// usb host lines and external rc network model
`timescale 1ns/1ps
module rswt_host_rc
(
   // clock
   input wire logic       clk,
   // bus mode: 0 idle, 1 activity, 2 se0
   input wire logic [1:0] busMode,
   // rc pin
   input wire logic       rcWakeOe,
   output logic           rcWakeIn,
   // usb lines
   output logic           dPlus,
   output logic           dMinus
);
   logic [4:0] chg = 5'h1f;
   logic       tgl = 1'b0;
   // cap charges via pull-up once released
   always @(posedge clk)
   begin
      tgl <= !tgl;
      if (rcWakeOe)
         chg <= 5'h00;
      else if (chg != 5'h1f)
         chg <= chg + 5'h01;
   end
   assign rcWakeIn = !rcWakeOe && chg > 5'h14;
   always_comb
   begin
      dPlus  = (busMode == 2'h1) ? tgl : 1'b0;
      dMinus = (busMode == 2'h1) ? !tgl : (busMode == 2'h0);
   end
endmodule

// >>> sim/rswt_reset_suspend_timer_tb.sv
// testbench of the reset, suspend and timer block
`timescale 1ns/1ps
module rswt_reset_suspend_timer_tb;
   import rswt_pkg::*;
   logic clk = 1'b0;
   logic resetn, gpioWake, dPlus, dMinus, rcWakeIn, rcWakeOut, rcWakeOe;
   logic cpuHold, cpuRun, cpuFetchZero, oscStop, sysResetPulse;
   logic usbTxDisable, irq128us, irq1ms, irqRcWake;
   logic [1:0] busMode;
   logic [7:0] ioRdData, v, w;
   rswt_io_req_type ioReq;
   int failures = 0, n_checks = 0, cyc = 0, n;
   wire [5:0] ev = {irq1ms, !cpuHold, irqRcWake, irq128us, cpuFetchZero,
      sysResetPulse};
   always #12.5 clk = ~clk;
   rswt_reset_suspend_timer #(.WAKE_CYC(8), .WDOG_HOLD_CYC(16))
      u_rswt_reset_suspend_timer (.clk(clk), .resetn(resetn),
      .ioReq(ioReq), .ioRdData(ioRdData), .dPlus(dPlus), .dMinus(dMinus),
      .gpioWake(gpioWake), .rcWakeIn(rcWakeIn), .rcWakeOut(rcWakeOut),
      .rcWakeOe(rcWakeOe), .cpuHold(cpuHold), .cpuRun(cpuRun),
      .cpuFetchZero(cpuFetchZero), .oscStop(oscStop),
      .sysResetPulse(sysResetPulse), .usbTxDisable(usbTxDisable),
      .irq128us(irq128us), .irq1ms(irq1ms), .irqRcWake(irqRcWake));
   rswt_host_rc u_rswt_host_rc (.clk(clk), .busMode(busMode),
      .rcWakeOe(rcWakeOe), .rcWakeIn(rcWakeIn), .dPlus(dPlus),
      .dMinus(dMinus));
   // ======
   // tasks
   task chk(input string s, input logic [15:0] seen, input logic [15:0] e);
      n_checks++;
      if (seen !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", s, e, seen);
      end
   endtask
   task step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      ioReq = {1'b0, 1'b1, a, d};
      step(1);
      ioReq.wr = 1'b0;
      step(1);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      ioReq = {1'b1, 1'b0, a, 8'h00};
      step(1);
      ioReq.rd = 1'b0;
      step(1);
      d = ioRdData;
   endtask
   task waitEv(input int i, input int lim);
      n = 0;
      while (ev[i] !== 1'b1 && n < lim)
      begin
         step(1);
         n++;
      end
   endtask
   task end_of_test;
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         failures++;
         end_of_test;
      end
   end
   // ======
   // tests
   initial
   begin
      ioReq = '0;
      gpioWake = 1'b0;
      busMode = 2'h0;
      resetn = 1'b0;
      step(10);
      resetn = 1'b1;
      rd(8'hff, v);
      chk("status", v, 8'h19);
      chk("osc", oscStop, 1);
      step(100);
      rd(8'h23, v);
      chk("timer", v, 0);
      gpioWake = 1'b1;
      step(20);
      chk("hold", cpuHold, 1);
      gpioWake = 1'b0;
      busMode = 2'h1;
      step(4);
      busMode = 2'h0;
      waitEv(1, 40);
      chk("fetch", n < 40, 1);
      chk("hold", cpuHold, 0);
      rd(8'h23, v);
      step(398);
      rd(8'h23, w);
      chk("tick", 8'(w - v), 10);
      waitEv(2, 6000);
      step(1);
      waitEv(2, 6000);
      chk("gap", n, 5119);
      waitEv(5, 42000);
      chk("nest", irq128us, 1);
      wr(8'h22, 8'h00);
      chk("oe", rcWakeOe, 1);
      rd(8'h22, v);
      chk("pin", v[0], 0);
      wr(8'h22, 8'h01);
      waitEv(3, 100);
      chk("rcirq", n < 100, 1);
      rd(8'h22, v);
      chk("pin", v[0], 1);
      busMode = 2'h2;
      step(660);
      rd(8'hff, v);
      chk("status", v, 8'h31);
      chk("hold", cpuHold, 1);
      busMode = 2'h0;
      waitEv(1, 5);
      chk("fetch", n < 5, 1);
      wr(8'hff, 8'h39);
      chk("osc", oscStop, 1);
      rd(8'h23, v);
      chk("timer", v, 0);
      gpioWake = 1'b1;
      step(1);
      gpioWake = 1'b0;
      waitEv(4, 40);
      chk("wake", n < 40, 1);
      chk("fetch", cpuFetchZero, 0);
      wr(8'hff, 8'h71);
      chk("txdis", usbTxDisable, 1);
      wr(8'hff, 8'h31);
      chk("txdis", usbTxDisable, 0);
      rd(8'h40, v);
      chk("unmapped", v, 0);
      wr(8'h22, 8'h00);
      wr(8'hff, 8'h30);
      chk("run", cpuRun, 0);
      wr(8'hff, 8'h31);
      rd(8'hff, v);
      chk("status", v, 8'h30);
      resetn = 1'b0;
      step(2);
      resetn = 1'b1;
      rd(8'hff, v);
      chk("status", v, 8'h19);
      chk("oe", rcWakeOe, 0);
      end_of_test;
   end
endmodule
